//--- verilog/external_bus_timing.sv
// timing and ready stage of the external bus controller
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`default_nettype none
module external_bus_timing
	import ext_bus_timing_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// avalon-mm register slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// access request from the cpu side
	input wire logic access_req,
	input wire logic access_write,
	input wire logic [23:0] access_addr,
	output logic access_busy,
	output logic access_done,
	// external bus pins
	input wire logic ready_n,
	output logic [23:0] ext_addr,
	output logic ale,
	output logic rd_n,
	output logic wr_n,
	output logic port0_addr_phase,
	// port ownership
	output logic port1_addr_en,
	output logic port1_gpio_ok,
	output logic ready_gpio_ok
);
	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [15:0] system_bus_config_reg; // default configuration
	logic [15:0] range_bus_config_reg; // configuration inside the range
	logic [15:0] range_address_select_reg; // base and enable of the range
	bus_cfg_s sys_cfg; // decoded system configuration
	bus_cfg_s range_cfg; // decoded range configuration
	bus_cfg_s sel_cfg; // configuration chosen for the new access
	bus_cfg_s cur_cfg_reg; // configuration held for the running access
	logic in_range; // new access hits the range
	seq_state_e state_reg; // sequencer state
	seq_state_e state_next;
	logic [4:0] cnt_reg; // cycles left in the current state
	logic [4:0] cnt_next;
	logic [4:0] cycle_wait_cyc; // cycle-time waits in clocks
	logic [4:0] tri_wait_cyc; // tristate waits in clocks
	logic [4:0] ale_cyc; // latch high time in clocks
	logic [4:0] hold_cyc; // address hold time in clocks
	logic last_mux_reg; // previous access was multiplexed
	logic write_reg; // direction of the running access
	logic ready_low; // synchronised ready pin, low means ready
	logic strobe_next; // read or write strobe active next
	logic end_strobe; // command part finishes this cycle
	logic reg_write; // avalon write takes effect
	logic [31:0] read_mux; // avalon read value

	////////////////////////////////////////////////////////////////////////
	// ready pin crossing
	logic ready_n_sync;

	// pin is asynchronous, two flops before any use
	level_sync #(
		.RESET_LEVEL(1'b1)
	) u_ready_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in(ready_n),
		.sync_out(ready_n_sync)
	);
	assign ready_low = !ready_n_sync;

	////////////////////////////////////////////////////////////////////////
	// avalon slave

	// one cycle of waitrequest then a one-cycle answer
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
		end
	end

	// a write lands at the edge where waitrequest is seen low
	assign reg_write = avs_write && !avs_waitrequest;

	// read value, unmapped offsets read zero
	always_comb begin
		read_mux = 32'h0000_0000;
		unique case (avs_address)
			OFS_SYSTEM_BUS_CONFIG: read_mux = {16'h0000, system_bus_config_reg};
			OFS_RANGE_BUS_CONFIG: read_mux = {16'h0000, range_bus_config_reg};
			OFS_RANGE_ADDRESS_SELECT: read_mux = {16'h0000, range_address_select_reg};
			OFS_STATUS: begin
				// live state of the sequencer and the pin ownership
				read_mux = {24'h00_0000, ready_low, last_mux_reg, port1_addr_en,
					ready_gpio_ok, access_busy, 3'(state_reg)};
			end
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// read data captured as waitrequest drops, stands in that cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && avs_waitrequest) begin
			avs_readdata <= read_mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration registers

	// software writes; reset gives one tristate wait and the delay on
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			system_bus_config_reg <= SYSTEM_CONFIG_RESET;
			range_bus_config_reg <= RANGE_CONFIG_RESET;
			range_address_select_reg <= RANGE_SELECT_RESET;
		end else if (reg_write) begin
			// upper half of the word is not implemented
			if (avs_address == OFS_SYSTEM_BUS_CONFIG) begin
				system_bus_config_reg <= avs_writedata[15:0];
			end
			if (avs_address == OFS_RANGE_BUS_CONFIG) begin
				range_bus_config_reg <= avs_writedata[15:0];
			end
			if (avs_address == OFS_RANGE_ADDRESS_SELECT) begin
				range_address_select_reg <= avs_writedata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration decode

	// fields sit in struct order; stretching exists only for the range
	assign sys_cfg = bus_cfg_s'({1'b0, system_bus_config_reg[POS_READY:POS_CYCLE_LSB]});
	assign range_cfg = bus_cfg_s'(range_bus_config_reg[POS_STRETCH:POS_CYCLE_LSB]);

	// per-access choice, so characteristics switch on the fly
	assign in_range = range_address_select_reg[POS_SEL_EN]
		&& (access_addr[23:16] == range_address_select_reg[POS_SEL_BASE_LSB +: 8]);
	assign sel_cfg = in_range ? range_cfg : sys_cfg;

	////////////////////////////////////////////////////////////////////////
	// phase lengths of the held access

	// waits are the inverse of the field; handshake uses the low three bits
	assign cycle_wait_cyc = (cur_cfg_reg.ready_en ? 5'({2'b00, ~cur_cfg_reg.cycle_field[2:0]})
		: 5'({1'b0, ~cur_cfg_reg.cycle_field})) * HALF_CYCLE_CYC;

	// programmed wait plus the implicit one of multiplexed modes
	always_comb begin
		tri_wait_cyc = 5'h00;
		if (!cur_cfg_reg.tristate_off) begin
			tri_wait_cyc = tri_wait_cyc + HALF_CYCLE_CYC;
		end
		if (cur_cfg_reg.mux) begin
			tri_wait_cyc = tri_wait_cyc + HALF_CYCLE_CYC;
		end
	end

	// one extra phase on both latch and hold when stretching
	assign ale_cyc = cur_cfg_reg.stretch ? HALF_CYCLE_CYC + STRETCH_CYC : HALF_CYCLE_CYC;
	assign hold_cyc = cur_cfg_reg.stretch ? HALF_CYCLE_CYC + STRETCH_CYC : HALF_CYCLE_CYC;

	////////////////////////////////////////////////////////////////////////
	// access sequencer next state

	// every count below is a whole number of phases
	always_comb begin
		state_next = state_reg;
		cnt_next = (cnt_reg != 5'h00) ? cnt_reg - 5'h01 : 5'h00;
		unique case (state_reg)
			ST_IDLE: begin
				if (access_req) begin
					if (sel_cfg.mux && !last_mux_reg) begin
						// bus mode flips to multiplexed: spare hold first
						state_next = ST_SWITCH_HOLD;
						cnt_next = HALF_CYCLE_CYC - 5'h01;
					end else begin
						state_next = ST_ADDR;
						// stretch comes from sel_cfg, not yet latched
						cnt_next = (sel_cfg.stretch ? HALF_CYCLE_CYC + STRETCH_CYC
							: HALF_CYCLE_CYC) - 5'h01;
					end
				end
			end
			ST_SWITCH_HOLD: begin
				if (cnt_reg == 5'h00) begin
					state_next = ST_ADDR;
					cnt_next = ale_cyc - 5'h01;
				end
			end
			ST_ADDR: begin
				if (cnt_reg == 5'h00) begin
					// command length is fixed, delay or not
					state_next = ST_CMD;
					cnt_next = FULL_CYCLE_CYC - 5'h01;
				end
			end
			ST_CMD: begin
				if (cnt_reg == 5'h00) begin
					if (cycle_wait_cyc != 5'h00) begin
						state_next = ST_WAIT;
						cnt_next = cycle_wait_cyc - 5'h01;
					end else if (cur_cfg_reg.ready_en) begin
						state_next = ST_READY;
					end else begin
						state_next = ST_HOLD;
						cnt_next = hold_cyc - 5'h01;
					end
				end
			end
			ST_WAIT: begin
				// ready is not looked at until the waits are spent
				if (cnt_reg == 5'h00) begin
					if (cur_cfg_reg.ready_en) begin
						state_next = ST_READY;
					end else begin
						state_next = ST_HOLD;
						cnt_next = hold_cyc - 5'h01;
					end
				end
			end
			ST_READY: begin
				// no timeout: a silent device stalls until reset
				if (ready_low) begin
					state_next = ST_HOLD;
					cnt_next = hold_cyc - 5'h01;
				end
			end
			ST_HOLD: begin
				if (cnt_reg == 5'h00) begin
					if (tri_wait_cyc != 5'h00) begin
						state_next = ST_TRI;
						cnt_next = tri_wait_cyc - 5'h01;
					end else begin
						state_next = ST_IDLE;
					end
				end
			end
			ST_TRI: begin
				// bus released, next address waits out the memory
				if (cnt_reg == 5'h00) begin
					state_next = ST_IDLE;
				end
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer registers

	// state and phase counter
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// access parameters held for the whole access
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur_cfg_reg <= '0;
			write_reg <= 1'b0;
			ext_addr <= 24'h00_0000;
		end else if (state_reg == ST_IDLE && access_req) begin
			cur_cfg_reg <= sel_cfg;
			write_reg <= access_write;
			ext_addr <= access_addr;
		end
	end

	// bus mode of the previous access, reset state nonmux
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			last_mux_reg <= 1'b0;
		end else if (state_reg == ST_ADDR && cnt_reg == 5'h00) begin
			last_mux_reg <= cur_cfg_reg.mux;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// strobes

	// first command phase skipped when the delay is on
	assign strobe_next = (state_reg == ST_CMD
		&& !(!cur_cfg_reg.strobe_delay_off && cnt_reg == FULL_CYCLE_CYC - 5'h01))
		|| state_reg == ST_WAIT || state_reg == ST_READY;
	assign end_strobe = state_next == ST_HOLD && state_reg != ST_HOLD;

	// latch and strobes share one register delay, so edges stay aligned
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ale <= 1'b0;
			rd_n <= 1'b1;
			wr_n <= 1'b1;
			port0_addr_phase <= 1'b0;
		end else begin
			ale <= state_reg == ST_ADDR;
			rd_n <= !(strobe_next && !write_reg);
			wr_n <= !(strobe_next && write_reg);
			port0_addr_phase <= state_reg == ST_ADDR && cur_cfg_reg.mux;
		end
	end

	// handshake with the cpu side
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			access_busy <= 1'b0;
			access_done <= 1'b0;
		end else begin
			access_busy <= state_next != ST_IDLE;
			access_done <= end_strobe;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port ownership

	// port 1 stays the address bus unless both system and range configurations are multiplexed
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			port1_addr_en <= 1'b1;
			port1_gpio_ok <= 1'b0;
			ready_gpio_ok <= 1'b1;
		end else begin
			port1_addr_en <= !(sys_cfg.mux && range_cfg.mux);
			port1_gpio_ok <= sys_cfg.mux && range_cfg.mux;
			ready_gpio_ok <= !sys_cfg.ready_en && !range_cfg.ready_en;
		end
	end
endmodule
`default_nettype wire

//--- common/ext_bus_timing_pkg.sv
// shared constants and types of the external bus timing stage
`default_nettype none
package ext_bus_timing_pkg;
	////////////////////////////////////////////////////////////////////////
	// register byte offsets on the avalon slave
	localparam logic [3:0] OFS_SYSTEM_BUS_CONFIG = 4'h0;
	localparam logic [3:0] OFS_RANGE_BUS_CONFIG = 4'h4;
	localparam logic [3:0] OFS_RANGE_ADDRESS_SELECT = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;
	////////////////////////////////////////////////////////////////////////
	// bus configuration field positions (both config registers)
	localparam int POS_CYCLE_LSB = 0; // cycle_time_wait_field, 4 bits
	localparam int POS_TRISTATE = 4; // tristate_wait_ctl
	localparam int POS_STROBE_DELAY = 5; // strobe_delay_ctl
	localparam int POS_MUX = 6; // 1 = multiplexed bus
	localparam int POS_READY = 7; // ready handshake enable
	localparam int POS_STRETCH = 8; // latch_stretch_en, range register only
	// range select field positions
	localparam int POS_SEL_BASE_LSB = 0; // 8 bits, compared to addr[23:16]
	localparam int POS_SEL_EN = 8;
	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [15:0] SYSTEM_CONFIG_RESET = 16'h0000;
	localparam logic [15:0] RANGE_CONFIG_RESET = 16'h0000;
	localparam logic [15:0] RANGE_SELECT_RESET = 16'h0000;
	////////////////////////////////////////////////////////////////////////
	// timing: one clock_phase_period is one sys_clk, four make a machine cycle
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLOCK_PHASE_PERIOD_NS = 40;
	localparam int PHASE_CYC = CLOCK_PHASE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PHASES_PER_CYCLE = 4;
	localparam logic [4:0] HALF_CYCLE_CYC = 5'(2 * PHASE_CYC);
	localparam logic [4:0] FULL_CYCLE_CYC = 5'(PHASES_PER_CYCLE * PHASE_CYC);
	localparam logic [4:0] STRETCH_CYC = 5'(PHASE_CYC);
	////////////////////////////////////////////////////////////////////////
	// decoded bus configuration for one access
	typedef struct packed {
		logic stretch;
		logic ready_en;
		logic mux;
		logic strobe_delay_off;
		logic tristate_off;
		logic [3:0] cycle_field;
	} bus_cfg_s;
	// access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_SWITCH_HOLD, ST_ADDR, ST_CMD, ST_WAIT, ST_READY, ST_HOLD, ST_TRI
	} seq_state_e;
endpackage
`default_nettype wire

//--- verilog/level_sync.sv
// two-flop synchroniser for an asynchronous pin level
`default_nettype none
module level_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	////////////////////////////////////////////////////////////////////////
	logic meta_reg; // first stage, read only by the second

	// two stages, nothing taps the first
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= RESET_LEVEL;
			sync_out <= RESET_LEVEL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

//--- tb/ext_bus_partner.sv
// behavioural external peripheral that drives the ready pin
`default_nettype none
module ext_bus_partner (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// strobes seen on the pins
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	// strobe cycles to stay not ready, 0 = fast memory
	input wire logic [7:0] slow_cycles,
	// ready pin, low = ready
	output logic ready_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] cnt_reg; // strobe cycles seen
	// flag not ready while the latch is open if slow_cycles is not 0, so the level is valid at its fall
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ready_n <= 1'b0;
			cnt_reg <= 8'h00;
		end else if (ale) begin
			ready_n <= (slow_cycles != 8'h00);
			cnt_reg <= 8'h00;
		end else if (!(rd_n && wr_n)) begin
			cnt_reg <= cnt_reg + 8'h01;
			// every access is answered sooner or later
			if (cnt_reg + 8'h01 >= slow_cycles) ready_n <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- tb/external_bus_timing_sva.sv
// assertions on the external bus timing stage ports
`default_nettype none
module external_bus_timing_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// access side
	input wire logic access_req,
	input wire logic access_busy,
	input wire logic access_done,
	// pins and ownership
	input wire logic [23:0] ext_addr,
	input wire logic ale,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic port0_addr_phase,
	input wire logic port1_addr_en,
	input wire logic port1_gpio_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////
	a_ale_two_phase: assert property ($rose(ale) |-> ##1 ale) else $error("ale short");
	a_strobe_quarter: assert property ($fell(rd_n) || $fell(wr_n) |-> $past(ale) || $past(ale, 2)) else $error("strobe late");
	a_ale_apart: assert property (ale |-> rd_n && wr_n) else $error("strobe in latch");
	a_strobe_min: assert property ($fell(rd_n) || $fell(wr_n) |-> !(rd_n && wr_n) [*3]) else $error("strobe short");
	a_done_rise: assert property (access_done |=> $rose(rd_n) || $rose(wr_n)) else $error("done off strobe");
	a_hold_after: assert property (access_done |=> access_busy) else $error("no hold");
	a_addr_steady: assert property (!rd_n && !$past(rd_n) |-> $stable(ext_addr)) else $error("addr moved");
	a_port1_owner: assert property (port1_gpio_ok != port1_addr_en) else $error("port1 owner");
	a_latch_take: assert property ($rose(access_busy) |-> ##[1:3] $rose(ale)) else $error("ale late");
	a_take_req: assert property ($rose(access_busy) |-> $past(access_req)) else $error("no request");
	a_mux_phase: assert property (port0_addr_phase |-> ale) else $error("addr phase");
	// stretched latch, delayed strobe, long read strobe
	c_stretch: cover property ($rose(ale) ##1 ale ##1 ale);
	c_delay: cover property ($fell(ale) ##1 $fell(rd_n));
	c_long: cover property (!rd_n [*8]);
endmodule
bind external_bus_timing external_bus_timing_sva u_sva (.sys_clk(sys_clk), .rstn(rstn),
	.access_req(access_req), .access_busy(access_busy), .access_done(access_done),
	.ext_addr(ext_addr), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
	.port0_addr_phase(port0_addr_phase), .port1_addr_en(port1_addr_en),
	.port1_gpio_ok(port1_gpio_ok));
`default_nettype wire

//--- tb/test_external_bus_timing.sv
// self-checking bench for the external bus timing stage
`default_nettype none
module test_external_bus_timing;
	import ext_bus_timing_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, q;
	logic avs_waitrequest, access_busy, access_done, ale, rd_n, wr_n;
	logic access_req = 1'b0;
	logic access_write = 1'b0;
	logic [23:0] access_addr = 24'h0;
	logic [23:0] ext_addr;
	logic port0_addr_phase, port1_addr_en, port1_gpio_ok, ready_gpio_ok, ready_n;
	logic [7:0] slow_cycles = 8'h00; // partner speed
	int n_mismatch = 0;
	int checks_done = 0;
	int ale_len, dly, str_len, total; // measured phases of last access
	int n_done, mux_len; // done pulses and address-phase cycles of last access
	always #20 sys_clk = ~sys_clk;
	external_bus_timing dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.access_req(access_req), .access_write(access_write), .access_addr(access_addr),
		.access_busy(access_busy), .access_done(access_done), .ready_n(ready_n),
		.ext_addr(ext_addr), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
		.port0_addr_phase(port0_addr_phase), .port1_addr_en(port1_addr_en),
		.port1_gpio_ok(port1_gpio_ok), .ready_gpio_ok(ready_gpio_ok));
	ext_bus_partner u_partner (.sys_clk(sys_clk), .rstn(rstn), .ale(ale), .rd_n(rd_n),
		.wr_n(wr_n), .slow_cycles(slow_cycles), .ready_n(ready_n));
	////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [15:0] d,
		output logic [31:0] rd);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 20) begin
			n_mismatch++;
			conclude();
		end
		// one idle edge so the next request is a separate assignment
		@(posedge sys_clk);
	endtask
	// one pin access, counting latch, delay, strobe and busy cycles
	task automatic do_access(input logic wr, input logic [23:0] a);
		logic seen;
		int n;
		seen = 1'b0;
		ale_len = 0;
		dly = 0;
		str_len = 0;
		total = 0;
		n_done = 0;
		mux_len = 0;
		access_req <= 1'b1;
		access_write <= wr;
		access_addr <= a;
		for (n = 0; n < 400; n++) begin
			@(posedge sys_clk);
			if (access_busy === 1'b1) begin
				seen = 1'b1;
				access_req <= 1'b0;
				total++;
				ale_len += int'(ale === 1'b1);
				n_done += int'(access_done === 1'b1);
				mux_len += int'(port0_addr_phase === 1'b1);
				if (rd_n === 1'b0 || wr_n === 1'b0) begin
					if (str_len == 0) check(32'(ext_addr), 32'(a));
					str_len++;
				end else if (ale_len > 0 && ale === 1'b0 && str_len == 0) begin
					dly++;
				end
			end else if (seen) begin
				break;
			end
		end
		if (n >= 400) begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic expect4(input int a, input int d, input int s, input int t);
		check(32'(ale_len), 32'(a));
		check(32'(dly), 32'(d));
		check(32'(str_len), 32'(s));
		check(32'(total), 32'(t));
		check(32'(n_done), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		check(32'({ale, rd_n, wr_n, access_busy, port1_addr_en, port1_gpio_ok,
			ready_gpio_ok}), 32'h35);
		bus_xfer(1'b0, OFS_SYSTEM_BUS_CONFIG, 16'h0000, q);
		check(q, 32'h0);
		bus_xfer(1'b0, 4'h2, 16'h0000, q);
		check(q, 32'h0);
		do_access(1'b0, 24'h00_1000);
		expect4(2, 1, 33, 40);
	endtask
	// wait counts, tristate and strobe delay from a table
	task automatic t_waits();
		logic [15:0] cfg [6] = '{16'h003f, 16'h003e, 16'h0038, 16'h0030, 16'h001f, 16'h002f};
		int w;
		foreach (cfg[i]) begin
			w = 2 * (15 - int'(cfg[i][3:0]));
			bus_xfer(1'b1, OFS_SYSTEM_BUS_CONFIG, cfg[i], q);
			do_access(i[0], 24'h00_0100);
			expect4(2, int'(!cfg[i][5]), 4 + w - int'(!cfg[i][5]),
				8 + w + 2 * int'(!cfg[i][4]));
		end
	endtask
	task automatic t_mux();
		bus_xfer(1'b1, OFS_SYSTEM_BUS_CONFIG, 16'h007f, q);
		do_access(1'b0, 24'h00_0200);
		expect4(2, 0, 4, 12);
		check(32'(mux_len), 32'h2);
		do_access(1'b1, 24'h00_0204);
		expect4(2, 0, 4, 10);
		check(32'(port1_gpio_ok), 32'h0);
		bus_xfer(1'b1, OFS_RANGE_BUS_CONFIG, 16'h0040, q);
		bus_xfer(1'b0, OFS_STATUS, 16'h0000, q);
		check(32'({port1_gpio_ok, q[5]}), 32'h2);
	endtask
	task automatic t_range();
		bus_xfer(1'b1, OFS_RANGE_ADDRESS_SELECT, 16'h0112, q);
		bus_xfer(1'b1, OFS_RANGE_BUS_CONFIG, 16'h013f, q);
		bus_xfer(1'b1, OFS_SYSTEM_BUS_CONFIG, 16'h003f, q);
		do_access(1'b0, 24'h12_3456);
		expect4(3, 0, 4, 10);
		do_access(1'b1, 24'h34_0000);
		expect4(2, 0, 4, 8);
	endtask
	// ready handshake: fast memory, early ready, slow peripheral
	task automatic t_ready();
		bus_xfer(1'b1, OFS_RANGE_ADDRESS_SELECT, 16'h0000, q);
		bus_xfer(1'b1, OFS_SYSTEM_BUS_CONFIG, 16'h00b7, q);
		@(posedge sys_clk);
		check(32'(ready_gpio_ok), 32'h0);
		do_access(1'b0, 24'h00_0300);
		check(32'(str_len inside {[4:6]}), 32'h1);
		bus_xfer(1'b1, OFS_SYSTEM_BUS_CONFIG, 16'h00bc, q);
		do_access(1'b1, 24'h00_0304);
		check(32'(str_len inside {[10:12]}), 32'h1);
		slow_cycles <= 8'h18;
		do_access(1'b0, 24'h00_0308);
		check(32'(str_len inside {[25:29]}), 32'h1);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_waits();
		t_mux();
		t_range();
		t_ready();
		conclude();
	end
endmodule
`default_nettype wire
